/* adc_seq_defs.svh */
`ifndef ADC_SEQ_DEFS_SVH
`define ADC_SEQ_DEFS_SVH
// Register offsets (low address bits of the converter block)
`define OFS_CONTROL       12'h500
`define OFS_POS_CHANNEL   12'h504
`define OFS_NEG_CHANNEL   12'h508
`define OFS_STATUS        12'h50C
`define OFS_RESULT        12'h510
`define OFS_REG_RESET     12'h514
`define OFS_PORT0_CONFIG  12'h518
// Reset values
`define CONTROL_RESET     16'h0A00
`define CHANNEL_RESET     5'h00
`define PORT0_RESET       1'h0
// Control field positions
`define CTL_DIV_HI        13
`define CTL_DIV_LO        11
`define CTL_ACQ_HI        10
`define CTL_ACQ_LO        8
`define CTL_ENABLE        7
`define CTL_POWER         5
`define CTL_MODE_HI       4
`define CTL_MODE_LO       3
`define CTL_TRIG_HI       2
`define CTL_TRIG_LO       0
// Codes
`define MODE_DIFF         2'h1
`define TRIG_PIN          3'h0
`define TRIG_TIMER1       3'h1
`define TRIG_TIMER0       3'h2
`define TRIG_SINGLE       3'h3
`define TRIG_CONT         3'h4
`define TRIG_PLA          3'h5
`define CHAN_TEMP         5'h0D
// Timing counts in converter clocks; TEMP_DIV_VAL is a divide ratio in system clocks
`define OVERHEAD_CLKS     7'd19
`define TEMP_ACQ_CLKS     7'd64
`define TEMP_ACQ_VAL      7'd16
`define TEMP_DIV_VAL      6'd32
`endif

/* adc_seq_pkg.sv */
`default_nettype none
package adc_seq_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ACQ  = 2'b01,
    ST_CONV = 2'b10
  } seq_state_e;

  // Timing latched at the start of a conversion
  typedef struct packed {
    logic [6:0] acq_clks;
    logic [5:0] div;
  } timing_s;

  // Register bus request
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [11:0] addr;
    logic [31:0] wdata;
  } mmr_req_s;
endpackage
`default_nettype wire

/* adc_sequencing_control.sv */
`include "adc_seq_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module adc_sequencing_control (
  input  wire logic                  sys_clk,
  input  wire logic                  resetn,
  input  wire adc_seq_pkg::mmr_req_s mmr_req,
  output logic [31:0]                mmr_rdata,
  input  wire logic                  external_convert_pin,
  input  wire logic                  timer0_pulse,
  input  wire logic                  timer1_pulse,
  input  wire logic                  pla_pulse,
  input  wire logic [11:0]           core_result,
  output logic [4:0]                 positive_channel_select,
  output logic [4:0]                 negative_channel_select,
  output logic [1:0]                 conv_mode,
  output logic                       temp_sensor_selected,
  output logic                       converter_power_up,
  output logic                       conv_clk_tick,
  output logic                       acquire_phase,
  output logic                       trial_phase,
  output logic                       converter_busy_out,
  output logic                       converter_irq,
  output logic                       port0_busy_out,
  output logic                       port0_busy_oe
);
  // Converter clock divide ratio for a field code
  function automatic logic [5:0] div_decode(input logic [2:0] code);
    div_decode = (code > 3'h5) ? 6'd32 : 6'(6'd1 << code);
  endfunction

  // Acquisition clocks for a field code
  function automatic logic [6:0] acq_decode(input logic [2:0] code);
    acq_decode = (code > 3'h5) ? 7'd64 : 7'(7'd2 << code);
  endfunction

  logic [15:0]             control_r;
  logic [4:0]              pos_r;
  logic [4:0]              neg_r;
  logic                    ready_r;
  logic [31:0]             result_r;
  logic                    port0_r;
  logic [31:0]             rdata_r;
  adc_seq_pkg::seq_state_e state_r;
  adc_seq_pkg::seq_state_e state_nxt;
  adc_seq_pkg::timing_s    timing_r;
  logic [5:0]              div_cnt_r;
  logic [6:0]              phase_cnt_r;
  logic                    pin_meta_r;
  logic                    pin_sync_r;
  logic                    t0_d_r;
  logic                    t1_d_r;
  logic                    pla_d_r;

  // Bus decode
  wire hit_ctl   = mmr_req.addr == `OFS_CONTROL;
  wire hit_pos   = mmr_req.addr == `OFS_POS_CHANNEL;
  wire hit_neg   = mmr_req.addr == `OFS_NEG_CHANNEL;
  wire hit_sta   = mmr_req.addr == `OFS_STATUS;
  wire hit_dat   = mmr_req.addr == `OFS_RESULT;
  wire hit_rst   = mmr_req.addr == `OFS_REG_RESET;
  wire hit_p0    = mmr_req.addr == `OFS_PORT0_CONFIG;
  wire reg_reset = mmr_req.wr && hit_rst;
  wire dat_read  = mmr_req.rd && hit_dat;

  // Field views
  wire [2:0] trig_sel  = control_r[`CTL_TRIG_HI:`CTL_TRIG_LO];
  wire       run_ok    = control_r[`CTL_ENABLE] && control_r[`CTL_POWER];
  wire       temp_chan = pos_r == `CHAN_TEMP;

  // Timing chosen for the next conversion; user timing fields never rewritten
  wire adc_seq_pkg::timing_s timing_sel = temp_chan ?
    '{acq_clks: `TEMP_ACQ_VAL, div: `TEMP_DIV_VAL} :
    '{acq_clks: acq_decode(control_r[`CTL_ACQ_HI:`CTL_ACQ_LO]),
      div:      div_decode(control_r[`CTL_DIV_HI:`CTL_DIV_LO])};

  // Trigger source select; pin is level so a held pin repeats
  wire t0_rise  = timer0_pulse && !t0_d_r;
  wire t1_rise  = timer1_pulse && !t1_d_r;
  wire pla_rise = pla_pulse && !pla_d_r;
  wire trigger  = (trig_sel == `TRIG_PIN)    ? pin_sync_r :
                  (trig_sel == `TRIG_TIMER1) ? t1_rise :
                  (trig_sel == `TRIG_TIMER0) ? t0_rise :
                  (trig_sel == `TRIG_SINGLE) ? 1'b1 :
                  (trig_sel == `TRIG_CONT)   ? 1'b1 :
                  (trig_sel == `TRIG_PLA)    ? pla_rise : 1'b0;

  // Converter clock tick from divider; phase ends gated by state, since
  // one phase counter serves both and the counts overlap
  wire tick      = (state_r != adc_seq_pkg::ST_IDLE) &&
                   (div_cnt_r == 6'(timing_r.div - 6'd1));
  wire acq_done  = tick && (state_r == adc_seq_pkg::ST_ACQ) &&
                   (phase_cnt_r == 7'(timing_r.acq_clks - 7'd1));
  wire conv_done = tick && (state_r == adc_seq_pkg::ST_CONV) &&
                   (phase_cnt_r == 7'(`OVERHEAD_CLKS - 7'd1));
  wire start     = (state_r == adc_seq_pkg::ST_IDLE) && run_ok && trigger;

  // Result formatting with sign extension in differential mode
  wire        diff_mode = control_r[`CTL_MODE_HI:`CTL_MODE_LO] == `MODE_DIFF;
  wire [3:0]  sign_ext  = diff_mode ? {4{core_result[11]}} : 4'h0;
  wire [31:0] result_fmt = {sign_ext, core_result, 16'h0000};

  // Read multiplexer
  wire [31:0] rd_mux = hit_ctl ? {16'h0000, control_r} :
                       hit_pos ? {27'h0, pos_r} :
                       hit_neg ? {27'h0, neg_r} :
                       hit_sta ? {31'h0, ready_r} :
                       hit_dat ? result_r :
                       hit_p0  ? {31'h0, port0_r} : 32'h0000_0000;

  // Sequencer next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      adc_seq_pkg::ST_IDLE: if (start) state_nxt = adc_seq_pkg::ST_ACQ;
      adc_seq_pkg::ST_ACQ:  if (acq_done) state_nxt = adc_seq_pkg::ST_CONV;
      adc_seq_pkg::ST_CONV: if (conv_done) state_nxt = adc_seq_pkg::ST_IDLE;
      default:              state_nxt = adc_seq_pkg::ST_IDLE;
    endcase
  end

  // Sequencer state, timing latch and counters
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_r     <= adc_seq_pkg::ST_IDLE;
      timing_r    <= '{acq_clks: 7'd8, div: 6'd2};
      div_cnt_r   <= 6'd0;
      phase_cnt_r <= 7'd0;
    end else begin
      state_r <= state_nxt;
      if (start) begin
        timing_r    <= timing_sel;
        div_cnt_r   <= 6'd0;
        phase_cnt_r <= 7'd0;
      end else if (state_r != adc_seq_pkg::ST_IDLE) begin
        div_cnt_r <= tick ? 6'd0 : 6'(div_cnt_r + 6'd1);
        if (acq_done || conv_done) begin
          phase_cnt_r <= 7'd0;
        end else if (tick) begin
          phase_cnt_r <= 7'(phase_cnt_r + 7'd1);
        end
      end
    end
  end

  // Pin synchroniser and trigger edge history
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pin_meta_r <= 1'b0;
      pin_sync_r <= 1'b0;
      t0_d_r     <= 1'b0;
      t1_d_r     <= 1'b0;
      pla_d_r    <= 1'b0;
    end else begin
      pin_meta_r <= external_convert_pin;
      pin_sync_r <= pin_meta_r;
      t0_d_r     <= timer0_pulse;
      t1_d_r     <= timer1_pulse;
      pla_d_r    <= pla_pulse;
    end
  end

  // Control and channel registers; reset command wins over a write
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      control_r <= `CONTROL_RESET;
      pos_r     <= `CHANNEL_RESET;
      neg_r     <= `CHANNEL_RESET;
      port0_r   <= `PORT0_RESET;
    end else if (reg_reset) begin
      control_r <= `CONTROL_RESET;
      pos_r     <= `CHANNEL_RESET;
      neg_r     <= `CHANNEL_RESET;
      port0_r   <= `PORT0_RESET;
    end else begin
      if (mmr_req.wr && hit_ctl) begin
        control_r <= mmr_req.wdata[15:0];
      end else if (conv_done && trig_sel == `TRIG_SINGLE) begin
        control_r[`CTL_TRIG_HI:`CTL_TRIG_LO] <= `TRIG_PIN;
      end
      if (mmr_req.wr && hit_pos) pos_r <= mmr_req.wdata[4:0];
      if (mmr_req.wr && hit_neg) neg_r <= mmr_req.wdata[4:0];
      if (mmr_req.wr && hit_p0) port0_r <= mmr_req.wdata[0];
    end
  end

  // Result, ready flag and read data; completion beats a clearing read
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      result_r <= 32'h0000_0000;
      ready_r  <= 1'b0;
      rdata_r  <= 32'h0000_0000;
    end else begin
      if (conv_done) begin
        result_r <= result_fmt;
        ready_r  <= 1'b1;
      end else if (dat_read || reg_reset) begin
        ready_r  <= 1'b0;
      end
      if (reg_reset && !conv_done) result_r <= 32'h0000_0000;
      if (mmr_req.rd) rdata_r <= rd_mux;
    end
  end

  // Outputs to the analog core and pins
  assign mmr_rdata               = rdata_r;
  assign positive_channel_select = pos_r;
  assign negative_channel_select = neg_r;
  assign temp_sensor_selected    = temp_chan;
  assign conv_mode               = control_r[`CTL_MODE_HI:`CTL_MODE_LO];
  assign converter_power_up      = control_r[`CTL_POWER];
  assign conv_clk_tick           = tick;
  assign acquire_phase           = state_r == adc_seq_pkg::ST_ACQ;
  assign trial_phase             = state_r == adc_seq_pkg::ST_CONV;
  assign converter_busy_out      = state_r != adc_seq_pkg::ST_IDLE;
  assign converter_irq           = ready_r;
  assign port0_busy_out          = converter_busy_out && port0_r;
  assign port0_busy_oe           = port0_r;
endmodule
`default_nettype wire

/* adc_seq_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_defs.svh"
module adc_seq_monitor (
  input wire logic        sys_clk,
  input wire logic        resetn,
  input wire adc_seq_pkg::mmr_req_s mmr_req,
  input wire logic        conv_clk_tick,
  input wire logic        acquire_phase,
  input wire logic        trial_phase,
  input wire logic        converter_busy_out,
  input wire logic        converter_irq,
  input wire logic        port0_busy_out,
  input wire logic        port0_busy_oe,
  input wire logic        temp_sensor_selected
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  logic [6:0] acq_n_r;
  logic [6:0] trial_n_r;
  wire        rd_res = mmr_req.rd && mmr_req.addr == `OFS_RESULT;
  // Ticks per phase; cleared when idle so each conversion counts from 0
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      acq_n_r <= 7'h00;
      trial_n_r <= 7'h00;
    end else begin
      acq_n_r <= converter_busy_out ? acq_n_r + 7'(acquire_phase & conv_clk_tick) : 7'h00;
      trial_n_r <= converter_busy_out ? trial_n_r + 7'(trial_phase & conv_clk_tick) : 7'h00;
    end
  end
  sequence conv_end;
    trial_phase ##1 !converter_busy_out;
  endsequence
  busy_phase_a: assert property (converter_busy_out == (acquire_phase || trial_phase))
    else $error("busy off phases");
  port_busy_a: assert property (port0_busy_out == (converter_busy_out && port0_busy_oe))
    else $error("port busy wrong");
  acq_first_a: assert property ($rose(converter_busy_out) |-> acquire_phase)
    else $error("no acquisition first");
  ready_raise_a: assert property (conv_end |-> converter_irq)
    else $error("ready not set");
  read_clear_a: assert property (rd_res && !converter_busy_out |=> !converter_irq)
    else $error("ready not cleared");
  trial_count_a: assert property (conv_end |-> trial_n_r == 7'd19)
    else $error("overhead count wrong");
  acq_code_a: assert property ($fell(acquire_phase) |-> acq_n_r inside {2, 4, 8, 16, 32, 64})
    else $error("acquisition count off table");
  temp_acq_a: assert property ($fell(acquire_phase) && temp_sensor_selected |-> acq_n_r == 7'd16)
    else $error("temperature acquisition wrong");
endmodule
bind adc_sequencing_control adc_seq_monitor u_mon (.sys_clk, .resetn, .mmr_req, .conv_clk_tick,
  .acquire_phase, .trial_phase, .converter_busy_out, .converter_irq, .port0_busy_out,
  .port0_busy_oe, .temp_sensor_selected);
`default_nettype wire

/* adc_core_model.sv */
`timescale 1ns/1ps
`default_nettype none
module adc_core_model #(
  parameter logic [11:0] SAMPLE_BASE = 12'hA5C
) (
  input wire logic        sys_clk,
  input wire logic        resetn,
  input wire logic [4:0]  positive_channel_select,
  input wire logic        acquire_phase,
  input wire logic        converter_busy_out,
  output logic [11:0]     core_result
);
  // Sample follows the mux input; toggles when idle so stale data never matches
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn)
      core_result <= 12'h000;
    else if (acquire_phase)
      core_result <= SAMPLE_BASE ^ {7'h00, positive_channel_select};
    else if (!converter_busy_out)
      core_result <= ~core_result;
  end
endmodule
`default_nettype wire

/* adc_sequencing_control_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_defs.svh"
module adc_sequencing_control_bench;
  logic                  sys_clk = 1'b0;
  logic                  resetn = 1'b0;
  adc_seq_pkg::mmr_req_s mmr_req = '0;
  logic                  external_convert_pin = 1'b0;
  logic                  timer0_pulse = 1'b0;
  logic                  timer1_pulse = 1'b0;
  logic                  pla_pulse = 1'b0;
  logic [31:0]           mmr_rdata, rd_val;
  logic [11:0]           core_result;
  logic [4:0]            positive_channel_select;
  logic                  acquire_phase, trial_phase, converter_busy_out, converter_irq;
  logic                  port0_busy_out, port0_busy_oe, temp_sensor_selected, conv_clk_tick;
  int                    fails = 0;
  int                    cmp_count = 0;
  int                    n;
  always #2.5 sys_clk = ~sys_clk;
  adc_sequencing_control uut (.sys_clk, .resetn, .mmr_req, .mmr_rdata, .external_convert_pin,
    .timer0_pulse, .timer1_pulse, .pla_pulse, .core_result, .positive_channel_select,
    .negative_channel_select(), .conv_mode(), .temp_sensor_selected, .converter_power_up(),
    .conv_clk_tick, .acquire_phase, .trial_phase, .converter_busy_out, .converter_irq,
    .port0_busy_out, .port0_busy_oe);
  adc_core_model model (.sys_clk, .resetn, .positive_channel_select, .acquire_phase,
    .converter_busy_out, .core_result);
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // One register access; read data lands the cycle after the strobe
  task automatic bus(input logic wr, input logic [11:0] addr, input logic [31:0] data);
    @(posedge sys_clk);
    mmr_req <= '{wr, !wr, addr, data};
    @(posedge sys_clk);
    mmr_req <= '0;
    #1 rd_val = mmr_rdata;
  endtask
  // Busy length in cycles, sampled at falling edges where outputs are settled
  task automatic measure;
    for (n = 0; converter_busy_out !== 1'b1 && n < 60; n++)
      @(negedge sys_clk);
    @(posedge sys_clk);
    {pla_pulse, timer0_pulse, timer1_pulse, external_convert_pin} <= 4'h0;
    @(negedge sys_clk);
    for (n = 1; converter_busy_out === 1'b1 && n < 1200; n++)
      @(negedge sys_clk);
  endtask
  task automatic test_reset_values;
    bus(1'b0, `OFS_CONTROL, 32'h0);
    check(rd_val, {16'h0000, `CONTROL_RESET});
    bus(1'b0, `OFS_STATUS, 32'h0);
    check(rd_val, 32'h00000000);
    bus(1'b0, 12'h51C, 32'h0);
    check(rd_val, 32'h00000000);
  endtask
  task automatic test_single_default;
    bus(1'b1, `OFS_CONTROL, 32'h00000AA3);
    measure;
    check(n, (8 + 19) * 2);
    check(converter_irq, 1'b1);
    bus(1'b0, `OFS_CONTROL, 32'h0);
    check(rd_val, 32'h00000AA0);
    bus(1'b0, `OFS_RESULT, 32'h0);
    check(rd_val, 32'h0A5C0000);
    check(converter_irq, 1'b0);
  endtask
  // Temperature override, then user timing and signed result on the next channel
  task automatic test_temp_override;
    bus(1'b1, `OFS_POS_CHANNEL, {27'h0, `CHAN_TEMP});
    check(temp_sensor_selected, 1'b1);
    bus(1'b1, `OFS_CONTROL, 32'h000000A3);
    measure;
    check(n, (16 + 19) * 32);
    bus(1'b0, `OFS_CONTROL, 32'h0);
    check(rd_val, 32'h000000A0);
    bus(1'b0, `OFS_RESULT, 32'h0);
    check(rd_val, 32'h0A510000);
    bus(1'b1, `OFS_POS_CHANNEL, 32'h00000002);
    bus(1'b1, `OFS_CONTROL, 32'h000000AB);
    measure;
    check(n, 2 + 19);
    bus(1'b0, `OFS_RESULT, 32'h0);
    check(rd_val, 32'hFA5E0000);
  endtask
  // Pin, timer 1, timer 0 and logic-array triggers, then continuous mode
  task automatic test_sources;
    bus(1'b1, `OFS_PORT0_CONFIG, 32'h00000001);
    check(port0_busy_oe, 1'b1);
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, `OFS_CONTROL, {29'h0000014, 3'(i == 3 ? 5 : i)});
      @(posedge sys_clk);
      {pla_pulse, timer0_pulse, timer1_pulse, external_convert_pin} <= 4'h1 << i;
      measure;
      check(n, 21);
      check(port0_busy_out, 1'b0);
    end
    bus(1'b1, `OFS_CONTROL, 32'h000000A4);
    measure;
    @(negedge sys_clk);
    check(port0_busy_out, 1'b1);
    measure;
    check(n, 21);
    bus(1'b1, `OFS_CONTROL, 32'h0);
  endtask
  task automatic test_reg_reset;
    for (n = 0; converter_busy_out !== 1'b0 && n < 60; n++)
      @(negedge sys_clk);
    bus(1'b1, `OFS_REG_RESET, 32'h0);
    bus(1'b0, `OFS_CONTROL, 32'h0);
    check(rd_val, {16'h0000, `CONTROL_RESET});
    bus(1'b0, `OFS_POS_CHANNEL, 32'h0);
    check(rd_val, 32'h00000000);
    bus(1'b0, `OFS_STATUS, 32'h0);
    check(rd_val, 32'h00000000);
    check(port0_busy_oe, 1'b0);
  endtask
  task automatic give_verdict;
    if (fails == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge sys_clk);
    resetn <= 1'b1;
    test_reset_values;
    test_single_default;
    test_temp_override;
    test_sources;
    test_reg_reset;
    give_verdict;
  end
  // Watchdog well past the longest expected run
  initial begin
    repeat (8000) @(posedge sys_clk);
    fails++;
    give_verdict;
  end
endmodule
`default_nettype wire
